//--- hdl/icq_unit.sv
// Interrupt, checkstop, reset-vector, quiesce and reservation control.
// Assumes active-low pins from outside the clock domain and same-clock bus error flags.
//
// Operation
// RL1: Allowed external interrupt is eventually taken.
// RL2: Machine check pin taken when both allowed.
// RL3: Pin with mchk disallowed requests checkstop.
// RL4: Checkstop gates off all internal clocks.
// RL5: Only cold reset leaves checkstop.
// RL6: Machine check while disallowed enters checkstop.
// RL7: Bus, parity, L2 errors are machine checks.
// RL8: Cold reset runs full initialization sequence.
// RL9: Warm reset skips cold initialization.
// RL10: Cold release or warm assertion starts fetch.
// RL11: Vector is prefix plus offset 0x00100.
// RL12: Cold reset selects the all-ones prefix.
// RL13: Quiesce request asserted before low power.
// RL14: System pauses snoops, then grants quiesce.
// RL15: Quiet only after grant; no snooping.
// RL16: Grant off eight bus cycles enables snoop.
// RL17: Grant reasserted returns to nap.
// RL18: Store-conditional succeeds only with valid reservation.
// RL19: Reservation covers an aligned 32-byte section.
// RL20: Asynchronous inputs are synchronized first.
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module icq_unit
	import icq_pkg::*;
#(
	parameter int COLD_INIT_CYCLES = 32,
	parameter int BUS_CLK_DIV = 4
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic ext_irq_n,
	input wire logic machine_check_pin_n,
	input wire logic halt_request_in_n,
	input wire logic cold_reset_n,
	input wire logic warm_reset_n,
	input wire logic quiesce_grant_n,
	input wire logic transfer_error_ack_n,
	input wire logic addr_parity_err,
	input wire logic data_parity_err,
	input wire logic l2_double_err,
	input wire logic lr_valid,
	input wire logic [31:0] lr_addr,
	input wire logic sc_valid,
	input wire logic [31:0] sc_addr,
	input wire logic snoop_hit_valid,
	input wire logic [31:0] snoop_addr,
	output logic sc_done,
	output logic sc_success,
	output logic take_ext_irq,
	output logic take_mchk,
	output logic clocks_enable,
	output logic checkstop,
	output logic cold_init_busy,
	output logic fetch_start,
	output logic [31:0] fetch_addr,
	output logic quiesce_request_n,
	output logic snoop_enable
);
	// ****************************************************************
	// Helpers.
	// ****************************************************************
	function automatic logic same_section(input logic [31:0] a, input logic [RES_W-1:0] s);
		same_section = (a[31:RES_LSB] == s);
	endfunction : same_section
	function automatic logic [31:0] vector_of(input logic ones);
		vector_of = {ones ? VEC_PREFIX_ONES : VEC_PREFIX_ZERO, VEC_OFFSET};
	endfunction : vector_of
	// ****************************************************************
	// Pin synchronizers with agreement filter.
	// ****************************************************************
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] sync3;
	logic [NPIN-1:0] pin;
	logic [NPIN-1:0] pin_prev;
	assign pin_raw = {quiesce_grant_n, warm_reset_n, cold_reset_n,
		halt_request_in_n, machine_check_pin_n, ext_irq_n};
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync1 <= PIN_IDLE;
			sync2 <= PIN_IDLE;
			sync3 <= PIN_IDLE;
			pin <= PIN_IDLE;
			pin_prev <= PIN_IDLE;
		end else begin
			sync1 <= pin_raw; // [RL20]
			sync2 <= sync1;
			sync3 <= sync2;
			pin <= (sync2 & sync3) | (pin & (sync2 | sync3)); // [RL20]
			pin_prev <= pin;
		end
	end
	logic ext_on;
	logic halt_on;
	logic cold_on;
	logic gnt;
	logic mcp_edge;
	logic warm_edge;
	logic cold_release;

	assign ext_on = ~pin[PIN_EXT];
	assign halt_on = ~pin[PIN_HALT];
	assign cold_on = ~pin[PIN_COLD];
	assign gnt = ~pin[PIN_QUIESCE_GRANT_N];
	assign mcp_edge = pin_prev[PIN_MCP] & ~pin[PIN_MCP];
	assign warm_edge = pin_prev[PIN_WARM] & ~pin[PIN_WARM];
	assign cold_release = ~pin_prev[PIN_COLD] & pin[PIN_COLD];
	// ****************************************************************
	// Machine check and checkstop.
	// ****************************************************************
	icq_ctrl_t ctrl;
	icq_ctrl_t next_ctrl;
	logic mchk_src;
	logic next_ckstp;
	logic do_ext;
	logic do_mchk;
	logic wake;
	always_comb begin
		mchk_src = ~transfer_error_ack_n | addr_parity_err | data_parity_err
			| l2_double_err | (mcp_edge & ctrl.mchk_pin_allow_bit); // [RL7] [RL2]
		next_ckstp = checkstop | halt_on | (mchk_src & ~ctrl.mchk_allow_bit); // [RL4] [RL3] [RL6]
		do_mchk = mchk_src & ctrl.mchk_allow_bit & ~checkstop & ~cold_on; // [RL2]
		do_ext = ext_on & ctrl.ext_irq_allow_bit & ~checkstop & ~cold_on; // [RL1]
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			checkstop <= 1'b0;
			clocks_enable <= 1'b1;
		end else if (cold_on) begin
			checkstop <= 1'b0; // [RL5]
			clocks_enable <= 1'b1;
		end else begin
			checkstop <= next_ckstp; // [RL5]
			clocks_enable <= ~next_ckstp; // [RL4]
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			take_ext_irq <= 1'b0;
			take_mchk <= 1'b0;
		end else begin
			take_ext_irq <= do_ext & ~do_mchk; // [RL1]
			take_mchk <= do_mchk; // [RL2]
		end
	end

	// ****************************************************************
	// Control register.
	// ****************************************************************
	always_comb begin
		next_ctrl = ctrl;
		if (reg_wr && reg_addr == OFS_CTRL) begin
			next_ctrl = icq_ctrl_t'(reg_wdata[5:0]);
		end
		if (do_ext && !do_mchk) begin
			next_ctrl.ext_irq_allow_bit = 1'b0;
		end
		if (do_mchk) begin
			next_ctrl.mchk_allow_bit = 1'b0;
		end
		if (wake) begin
			next_ctrl.lp_request = 1'b0;
		end
	end
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctrl <= icq_ctrl_t'(CTRL_RST);
		end else if (cold_on) begin
			ctrl <= icq_ctrl_t'(CTRL_RST); // [RL12]
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ****************************************************************
	// Cold initialization and reset vector fetch.
	// ****************************************************************
	logic [15:0] init_cnt;
	logic fetch_pend;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			init_cnt <= 16'(COLD_INIT_CYCLES);
			cold_init_busy <= 1'b1;
			fetch_pend <= 1'b1;
		end else if (cold_on) begin
			init_cnt <= 16'(COLD_INIT_CYCLES); // [RL8]
			cold_init_busy <= 1'b1;
			fetch_pend <= 1'b0;
		end else begin
			if (init_cnt != 16'h0000) begin
				init_cnt <= init_cnt - 16'h0001; // [RL8]
			end
			cold_init_busy <= (init_cnt > 16'h0001);
			if (cold_release) begin
				fetch_pend <= 1'b1;
			end else if (init_cnt == 16'h0000) begin
				fetch_pend <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			fetch_start <= 1'b0;
			fetch_addr <= 32'h0000_0000;
		end else begin
			fetch_start <= ~cold_on & ~checkstop
				& ((fetch_pend & (init_cnt == 16'h0000)) | warm_edge); // [RL10] [RL9]
			fetch_addr <= vector_of(ctrl.vector_prefix_sel); // [RL11]
		end
	end
	// ****************************************************************
	// Quiesce handshake and nap snooping.
	// ****************************************************************
	icq_pm_t pm;
	icq_pm_t next_pm;
	logic [7:0] div_cnt;
	logic bus_tick;
	logic [3:0] off_ticks;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_cnt <= 8'h00;
			bus_tick <= 1'b0;
		end else begin
			bus_tick <= (div_cnt == 8'(BUS_CLK_DIV - 1));
			div_cnt <= (div_cnt == 8'(BUS_CLK_DIV - 1)) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			off_ticks <= 4'h0;
		end else if (pm != PM_QUIET || gnt) begin
			off_ticks <= 4'h0;
		end else if (bus_tick && off_ticks != SNOOP_TICKS) begin
			off_ticks <= off_ticks + 4'h1; // [RL16]
		end
	end

	assign wake = (pm != PM_RUN) & (~ctrl.lp_request | do_ext | do_mchk);
	always_comb begin
		next_pm = pm;
		case (pm)
			PM_RUN: begin
				if (ctrl.lp_request && !checkstop && !cold_on) begin
					next_pm = PM_REQ; // [RL13]
				end
			end
			PM_REQ: begin
				if (wake) begin
					next_pm = PM_RUN;
				end else if (gnt) begin
					next_pm = PM_QUIET; // [RL15]
				end
			end
			PM_QUIET: begin
				if (wake) begin
					next_pm = PM_RUN;
				end else if (!ctrl.lp_sleep && off_ticks == SNOOP_TICKS) begin
					next_pm = PM_SNOOP; // [RL16]
				end
			end
			PM_SNOOP: begin
				if (wake) begin
					next_pm = PM_RUN;
				end else if (gnt) begin
					next_pm = PM_QUIET; // [RL17]
				end
			end
			default: begin
				next_pm = PM_RUN;
			end
		endcase
		if (cold_on || checkstop) begin
			next_pm = PM_RUN;
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pm <= PM_RUN;
			quiesce_request_n <= 1'b1;
			snoop_enable <= 1'b1;
		end else begin
			pm <= next_pm;
			quiesce_request_n <= (next_pm == PM_RUN); // [RL13]
			snoop_enable <= (next_pm != PM_QUIET); // [RL15]
		end
	end
	// ****************************************************************
	// Reservation for load-reserve and store-conditional.
	// ****************************************************************
	logic res_valid;
	logic [RES_W-1:0] res_sec;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			res_valid <= 1'b0;
			res_sec <= '0;
		end else if (cold_on) begin
			res_valid <= 1'b0;
		end else if (lr_valid) begin
			res_valid <= 1'b1; // [RL18]
			res_sec <= lr_addr[31:RES_LSB]; // [RL19]
		end else if (sc_valid) begin
			res_valid <= 1'b0;
		end else if (snoop_hit_valid && same_section(snoop_addr, res_sec)) begin
			res_valid <= 1'b0; // [RL19]
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sc_done <= 1'b0;
			sc_success <= 1'b0;
		end else begin
			sc_done <= sc_valid & ~lr_valid;
			sc_success <= sc_valid & ~lr_valid & res_valid
				& same_section(sc_addr, res_sec); // [RL18] [RL19]
		end
	end
	// ****************************************************************
	// Register read port.
	// ****************************************************************
	icq_stat_t stat;
	assign stat = '{snoop_enable: snoop_enable, init_busy: cold_init_busy,
		res_valid: res_valid, pm: pm, checkstop: checkstop};
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == OFS_CTRL) begin
			reg_rdata <= {26'h0, ctrl};
		end else if (reg_addr == OFS_STAT) begin
			reg_rdata <= {25'h0, stat};
		end else if (reg_addr == OFS_RES) begin
			reg_rdata <= {res_sec, {RES_LSB{1'b0}}};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	sequence s_req_to_quiet;
		pm == PM_REQ ##1 pm == PM_QUIET;
	endsequence
	sequence s_reserve_then_sc;
		lr_valid ##1 (sc_valid && !lr_valid && same_section(sc_addr, res_sec));
	endsequence
	a_ext_irq_take: assert property (do_ext && !do_mchk |=> take_ext_irq) // [RL1]
		else $error("allowed external interrupt not taken");
	a_mchk_take: assert property (do_mchk |=> take_mchk && !checkstop) // [RL2]
		else $error("allowed machine check not taken");
	a_mchk_ckstp: assert property (mchk_src && !ctrl.mchk_allow_bit && !cold_on |=> checkstop) // [RL6]
		else $error("disallowed machine check did not checkstop");
	a_halt_ckstp: assert property (halt_on && !cold_on |=> checkstop && !clocks_enable) // [RL4]
		else $error("halt request did not gate clocks");
	a_ckstp_hold: assert property (checkstop && !cold_on |=> checkstop) // [RL5]
		else $error("checkstop left without cold reset");
	a_cold_prefix: assert property (cold_on |=> ctrl.vector_prefix_sel && cold_init_busy) // [RL12]
		else $error("cold reset did not select ones prefix");
	a_vector_addr: assert property (fetch_start |-> fetch_addr[19:0] == VEC_OFFSET) // [RL11]
		else $error("reset vector offset wrong");
	a_warm_fetch: assert property (warm_edge && !cold_on && !checkstop |=> fetch_start) // [RL10]
		else $error("warm reset did not start fetch");
	a_quiet_grant: assert property (s_req_to_quiet |-> $past(gnt)) // [RL15]
		else $error("quiet entered without grant");
	a_quiet_nosnoop: assert property (pm == PM_QUIET |-> !snoop_enable && !quiesce_request_n) // [RL15]
		else $error("snooping while quiet");
	a_snoop_wait: assert property ($rose(snoop_enable) && pm == PM_SNOOP |-> !$past(gnt, 8)) // [RL16]
		else $error("snoop enabled too early");
	a_snoop_back: assert property (pm == PM_SNOOP && gnt && !wake && !checkstop |=> pm == PM_QUIET) // [RL17]
		else $error("no return to nap after grant");
	a_sc_reserved: assert property (s_reserve_then_sc |=> sc_success) // [RL18]
		else $error("store-conditional failed with reservation");
	a_sc_noresv: assert property (sc_valid && !lr_valid && !res_valid |=> sc_done && !sc_success) // [RL18]
		else $error("store-conditional succeeded without reservation");
endmodule : icq_unit
`default_nettype wire

//--- hdl/icq_pkg.sv
// Constants, field layouts and types for the interrupt, checkstop, reset and quiesce unit.
// Assumes a single 40 MHz core clock and a plain register port with byte addresses.
package icq_pkg;
	// ****************************************************************
	// Register map.
	// ****************************************************************
	localparam int ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STAT = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_RES = 4'h8;
	localparam logic [5:0] CTRL_RST = 6'h08;
	// ****************************************************************
	// Pin vector positions, all pins active low.
	// ****************************************************************
	localparam int NPIN = 6;
	localparam int PIN_EXT = 0;
	localparam int PIN_MCP = 1;
	localparam int PIN_HALT = 2;
	localparam int PIN_COLD = 3;
	localparam int PIN_WARM = 4;
	localparam int PIN_QUIESCE_GRANT_N = 5;
	localparam logic [NPIN-1:0] PIN_IDLE = 6'h3f;
	// ****************************************************************
	// Reset vector and reservation granule.
	// ****************************************************************
	localparam logic [19:0] VEC_OFFSET = 20'h00100;
	localparam logic [11:0] VEC_PREFIX_ONES = 12'hfff;
	localparam logic [11:0] VEC_PREFIX_ZERO = 12'h000;
	localparam int RES_BYTES = 32;
	localparam int RES_LSB = $clog2(RES_BYTES);
	localparam int RES_W = 32 - RES_LSB;
	// ****************************************************************
	// Timing.
	// ****************************************************************
	localparam int CLK_MHZ = 40;
	localparam int SNOOP_BUS_CYCLES = 8;
	localparam logic [3:0] SNOOP_TICKS = 4'(SNOOP_BUS_CYCLES);
	// ****************************************************************
	// Types.
	// ****************************************************************
	typedef struct packed {
		logic lp_sleep;
		logic lp_request;
		logic vector_prefix_sel;
		logic mchk_pin_allow_bit;
		logic mchk_allow_bit;
		logic ext_irq_allow_bit;
	} icq_ctrl_t;
	typedef enum logic [2:0] {
		PM_RUN = 3'b000,
		PM_REQ = 3'b001,
		PM_QUIET = 3'b010,
		PM_SNOOP = 3'b011
	} icq_pm_t;
	typedef struct packed {
		logic snoop_enable;
		logic init_busy;
		logic res_valid;
		icq_pm_t pm;
		logic checkstop;
	} icq_stat_t;
endpackage : icq_pkg

//--- bench/icq_sys_model.sv
// System-side model: grants quiesce and opens snoop windows in nap.
// Assumes the unit's quiesce request and the bench's snoop window request.
`timescale 1ns/1ps
`default_nettype none
module icq_sys_model
	import icq_pkg::*;
#(
	parameter int GRANT_DLY = 3
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic quiesce_request_n,
	input wire logic snoop_win,
	output logic quiesce_grant_n
);
	logic [7:0] cnt;
	// ****************************************************************
	// Grant after a pause, released while snoops are wanted.
	// ****************************************************************
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt <= 8'h00;
			quiesce_grant_n <= 1'b1;
		end else if (quiesce_request_n) begin
			cnt <= 8'h00;
			quiesce_grant_n <= 1'b1;
		end else if (snoop_win) begin
			quiesce_grant_n <= 1'b1;
		end else if (cnt < 8'(GRANT_DLY)) begin
			cnt <= cnt + 8'h01;
		end else begin
			quiesce_grant_n <= 1'b0;
		end
	end
endmodule : icq_sys_model
`default_nettype wire

//--- bench/tb_interrupt_checkstop_reset_quiesce.sv
// Self-checking bench for the interrupt, checkstop, reset and quiesce unit.
// Assumes a 40 MHz core clock and the system model on the quiesce pins.
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_checkstop_reset_quiesce;
	import icq_pkg::*;
	logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, lr_addr = '0, sc_addr = '0, snoop_addr = '0;
	logic [31:0] fetch_addr, d, a;
	logic [NPIN-1:0] pins = PIN_IDLE;
	logic [3:0] errs = 4'h0;
	logic lr_valid = 1'b0, sc_valid = 1'b0, snoop_hit_valid = 1'b0, snoop_win = 1'b0;
	logic sc_done, sc_success, take_ext_irq, take_mchk, clocks_enable, checkstop;
	logic cold_init_busy, fetch_start, quiesce_request_n, snoop_enable, grant_n, hit;
	int mismatches = 0, num_checks = 0;
	always #12.5 core_clk = ~core_clk;
	icq_unit #(.COLD_INIT_CYCLES(4), .BUS_CLK_DIV(2)) dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_n(pins[PIN_EXT]),
		.machine_check_pin_n(pins[PIN_MCP]), .halt_request_in_n(pins[PIN_HALT]),
		.cold_reset_n(pins[PIN_COLD]), .warm_reset_n(pins[PIN_WARM]),
		.quiesce_grant_n(grant_n), .transfer_error_ack_n(~errs[0]),
		.addr_parity_err(errs[1]), .data_parity_err(errs[2]), .l2_double_err(errs[3]),
		.lr_valid(lr_valid), .lr_addr(lr_addr), .sc_valid(sc_valid), .sc_addr(sc_addr),
		.snoop_hit_valid(snoop_hit_valid), .snoop_addr(snoop_addr), .sc_done(sc_done),
		.sc_success(sc_success), .take_ext_irq(take_ext_irq), .take_mchk(take_mchk),
		.clocks_enable(clocks_enable), .checkstop(checkstop),
		.cold_init_busy(cold_init_busy), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
		.quiesce_request_n(quiesce_request_n), .snoop_enable(snoop_enable));
	icq_sys_model #(.GRANT_DLY(3)) partner (.core_clk(core_clk), .sys_rst(sys_rst),
		.quiesce_request_n(quiesce_request_n), .snoop_win(snoop_win),
		.quiesce_grant_n(grant_n));
	// ****************************************************************
	// Expectations, checks and bus cycles.
	// ****************************************************************
	function automatic logic [31:0] vec(input logic ones);
		vec = ones ? {VEC_PREFIX_ONES, VEC_OFFSET} : {VEC_PREFIX_ZERO, VEC_OFFSET};
	endfunction : vec
	function automatic logic same_sec(input logic [31:0] x, input logic [31:0] y);
		same_sec = (x[31:RES_LSB] == y[31:RES_LSB]);
	endfunction : same_sec
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [ADDR_W-1:0] ad, input logic [31:0] dt);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= dt;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] ad, output logic [31:0] dt);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 dt = reg_rdata;
	endtask : rd
	task automatic wt(input int sel, input int lim);
		hit = 1'b0;
		repeat (lim) begin
			@(posedge core_clk);
			#1;
			case (sel)
				0: hit = (fetch_start === 1'b1);
				1: hit = (take_ext_irq === 1'b1);
				2: hit = (take_mchk === 1'b1);
				3: hit = (checkstop === 1'b1);
				4: hit = (quiesce_request_n === 1'b0);
				5: hit = (snoop_enable === 1'b0);
				default: hit = (snoop_enable === 1'b1);
			endcase
			if (hit) break;
		end
	endtask : wt
	task automatic pin(input int idx, input int cyc);
		@(posedge core_clk);
		pins[idx] <= 1'b0;
		fork
			begin
				repeat (cyc) @(posedge core_clk);
				pins[idx] <= 1'b1;
			end
		join_none
	endtask : pin
	task automatic sc(input logic [31:0] ad, input logic exp);
		@(posedge core_clk);
		sc_valid <= 1'b1;
		sc_addr <= ad;
		lr_valid <= 1'b0;
		@(posedge core_clk);
		sc_valid <= 1'b0;
		#1;
		chk(sc_done, 1'b1);
		chk(sc_success, exp);
	endtask : sc
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	initial begin
		#(25.0 * 20000);
		mismatches++;
		results();
	end
	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		void'($urandom(32'ha25b));
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		#1 chk(cold_init_busy, 1'b1);
		wt(0, 60);
		chk(hit, 1'b1);
		chk(fetch_addr, vec(1'b1));
		rd(OFS_CTRL, d);
		chk(d, 32'(CTRL_RST));
		rd(4'hc, d);
		chk(d, 32'h0);
		d = $urandom & 32'h0f;
		wr(OFS_CTRL, d);
		rd(OFS_CTRL, a);
		chk(a, d);
		// Reservation granule, random and corner addresses.
		for (int i = 0; i < 10; i++) begin
			a = $urandom;
			d = (i % 3 == 0) ? a ^ 32'h20 : {a[31:5], 5'(i * 7)};
			@(posedge core_clk);
			lr_valid <= 1'b1;
			lr_addr <= a;
			if (i % 2 == 1) begin
				@(posedge core_clk);
				lr_valid <= 1'b0;
			end
			sc(d, same_sec(a, d));
		end
		sc(a, 1'b0);
		@(posedge core_clk);
		lr_valid <= 1'b1;
		lr_addr <= 32'h1004;
		@(posedge core_clk);
		lr_valid <= 1'b0;
		snoop_hit_valid <= 1'b1;
		snoop_addr <= 32'h101c;
		@(posedge core_clk);
		snoop_hit_valid <= 1'b0;
		sc(32'h1004, 1'b0);
		rd(OFS_RES, d);
		chk(d, 32'h0000_1000);
		// External interrupt held off while not allowed, then taken.
		wr(OFS_CTRL, 32'h0);
		pins[PIN_EXT] <= 1'b0;
		wt(1, 12);
		chk(hit, 1'b0);
		wr(OFS_CTRL, 32'h01);
		wt(1, 12);
		chk(hit, 1'b1);
		@(posedge core_clk);
		pins[PIN_EXT] <= 1'b1;
		rd(OFS_CTRL, d);
		chk(d[0], 1'b0);
		// Every bus-side machine check source, and the pin.
		for (int s = 0; s < 5; s++) begin
			wr(OFS_CTRL, 32'h06);
			if (s < 4) begin
				errs[s] <= 1'b1;
				@(posedge core_clk);
				errs <= 4'h0;
				#1 hit = (take_mchk === 1'b1);
			end else begin
				pin(PIN_MCP, 6);
				wt(2, 12);
			end
			chk(hit, 1'b1);
		end
		// Warm reset with the zero prefix.
		wr(OFS_CTRL, 32'h0);
		pin(PIN_WARM, 6);
		wt(0, 12);
		chk(hit, 1'b1);
		chk(fetch_addr, vec(1'b0));
		chk(cold_init_busy, 1'b0);
		// Nap: request, grant, snoop window, back to nap, wake.
		wr(OFS_CTRL, 32'h10);
		wt(4, 10);
		chk(hit, 1'b1);
		wt(5, 30);
		chk(hit, 1'b1);
		rd(OFS_STAT, d);
		chk(d[3:1], 32'(PM_QUIET));
		@(posedge core_clk);
		snoop_win <= 1'b1;
		repeat (12) @(posedge core_clk);
		#1 chk(snoop_enable, 1'b0);
		wt(6, 40);
		chk(hit, 1'b1);
		snoop_win <= 1'b0;
		wt(5, 20);
		chk(hit, 1'b1);
		wr(OFS_CTRL, 32'h0);
		wt(6, 10);
		chk(quiesce_request_n, 1'b1);
		// Checkstop from a data parity error, the machine check pin and halt; only cold reset clears it.
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, 32'h04);
			if (k == 0) begin
				errs[2] <= 1'b1;
				@(posedge core_clk);
				errs <= 4'h0;
			end else begin
				pin(k == 1 ? PIN_MCP : PIN_HALT, 6);
			end
			wt(3, 12);
			chk(hit, 1'b1);
			chk(take_mchk, 1'b0);
			chk(clocks_enable, 1'b0);
			pin(PIN_WARM, 6);
			wt(0, 12);
			chk(hit, 1'b0);
			chk(checkstop, 1'b1);
			pin(PIN_COLD, 6);
			wt(0, 30);
			chk(hit, 1'b1);
			chk(fetch_addr, vec(1'b1));
			chk(checkstop, 1'b0);
			chk(clocks_enable, 1'b1);
		end
		rd(OFS_STAT, d);
		chk(d[0], 1'b0);
		results();
	end
endmodule : tb_interrupt_checkstop_reset_quiesce
`default_nettype wire
